// ==== ssv_pkg.sv ====
/*
 * Package for the sensor supervisor objects: service codes, attribute
 * numbers, reset values, field positions and supervisor states.
 * Assumes the node's single 200 MHz clock domain.
 */
`default_nettype none
package ssv_pkg;
	// Service codes.
	localparam logic [7:0] SVC_GET      = 8'h0E;
	localparam logic [7:0] SVC_SET      = 8'h10;
	localparam logic [7:0] SVC_RESET    = 8'h05;
	localparam logic [7:0] SVC_START    = 8'h06;
	localparam logic [7:0] SVC_STOP     = 8'h07;
	localparam logic [7:0] SVC_ABORT    = 8'h4B;
	localparam logic [7:0] SVC_RECOVER  = 8'h4C;
	localparam logic [7:0] SVC_DIAG     = 8'h4E;
	// Object class codes.
	localparam logic [7:0] CLS_SENSOR   = 8'h31;
	localparam logic [7:0] CLS_SUPER    = 8'h30;
	// Sensor attribute numbers.
	localparam logic [7:0] ATT_REVISION = 8'h01;
	localparam logic [7:0] ATT_SUBCLASS = 8'h63;
	localparam logic [7:0] ATT_FORMAT   = 8'h03;
	localparam logic [7:0] ATT_UNITS    = 8'h04;
	localparam logic [7:0] ATT_VALID    = 8'h05;
	localparam logic [7:0] ATT_VALUE    = 8'h06;
	localparam logic [7:0] ATT_STATUS   = 8'h07;
	localparam logic [7:0] ATT_ALM_EN   = 8'h08;
	localparam logic [7:0] ATT_WRN_EN   = 8'h09;
	localparam logic [7:0] ATT_SPAN     = 8'h0A;
	localparam logic [7:0] ATT_OFS_B    = 8'h10;
	// Supervisor attribute numbers chosen for the state and the exception details.
	localparam logic [7:0] ATT_STATE    = 8'h05;
	localparam logic [7:0] ATT_ALM_DET  = 8'h0A;
	localparam logic [7:0] ATT_WRN_DET  = 8'h0B;
	localparam logic [7:0] ATT_MFG_ALM  = 8'h0C;
	localparam logic [7:0] ATT_MFG_WRN  = 8'h0D;
	// Reset values.
	localparam logic [15:0] CLS_REV_VAL = 16'h0001;
	localparam logic [7:0]  FMT_INT     = 8'hC3;
	localparam logic [7:0]  FMT_REAL    = 8'hCA;
	localparam logic [15:0] UNITS_RST   = 16'h1001;
	localparam logic        ENABLE_RST  = 1'b1;
	localparam logic [15:0] OFS_B_RST   = 16'h0000;
	localparam logic [15:0] SPAN_VAL    = 16'h7FFF;
	// Detail and status field positions.
	localparam int DET_VALID = 0;
	localparam int DET_OVER  = 1;
	localparam int DET_UNDER = 2;
	localparam int MFG_TEMP  = 0;
	localparam int ST_HI_ALM = 0;
	localparam int ST_LO_ALM = 1;
	localparam int ST_HI_WRN = 2;
	localparam int ST_LO_WRN = 3;
	// Answer codes.
	localparam logic [7:0] ERR_NONE     = 8'h00;
	localparam logic [7:0] ERR_STATE    = 8'h0C;
	localparam logic [7:0] ERR_NO_ATTR  = 8'h14;
	localparam logic [7:0] ERR_RO_ATTR  = 8'h0E;
	localparam logic [7:0] ERR_VALUE    = 8'h09;
	localparam logic [7:0] ERR_SERVICE  = 8'h08;
	localparam logic [7:0] ERR_OBJECT   = 8'h16;
	// Diagnostic run length in cycles.
	localparam int DIAG_CYCLES = 16;

	typedef enum logic [4:0] {
		ST_SELFTEST = 5'b00001,
		ST_IDLE     = 5'b00010,
		ST_EXEC     = 5'b00100,
		ST_ABORT    = 5'b01000,
		ST_FAULT    = 5'b10000
	} ssv_state_t;
endpackage
`default_nettype wire

// ==== ssv_corr_if.sv ====
/*
 * Interface carrying the correction request and result between the
 * supervisor top and its correction datapath. Same clock on both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface ssv_corr_if;
	logic signed [15:0] raw;
	logic signed [15:0] ofs_a;
	logic signed [15:0] gain;
	logic signed [15:0] ofs_b;
	logic signed [15:0] result;
	logic               ovr;
	logic               unr;
	modport top  (output raw, ofs_a, gain, ofs_b, input result, ovr, unr);
	modport corr (input raw, ofs_a, gain, ofs_b, output result, ovr, unr);
endinterface
`default_nettype wire

// ==== ssv_corr.sv ====
/*
 * Correction datapath: gain times (reading plus first offset), plus the
 * second offset, saturated to 16 bits. Gain is Q8.8 fixed point.
 * Assumes registered inputs on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ssv_corr
	import ssv_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	ssv_corr_if.corr  c
);
	localparam int FRAC = 8;
	logic signed [16:0] sum_w;
	logic signed [33:0] prod_w;
	logic signed [34:0] tot_w;
	logic               ovr_w;
	logic               unr_w;

	assign sum_w  = 17'(c.raw) + 17'(c.ofs_a);
	assign prod_w = 34'(sum_w) * 34'(c.gain);
	assign tot_w  = 35'(prod_w >>> FRAC) + 35'(c.ofs_b);
	assign ovr_w  = tot_w > 35'sd32767;
	assign unr_w  = tot_w < -35'sd32768;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			c.result <= '0;
			c.ovr    <= 1'b0;
			c.unr    <= 1'b0;
		end else begin
			c.result <= ovr_w ? 16'sh7FFF : unr_w ? -16'sh8000 : tot_w[15:0];
			c.ovr    <= ovr_w;
			c.unr    <= unr_w;
		end
	end
endmodule
`default_nettype wire

// ==== ssv_top.sv ====
/*
 * Supervisor and analog sensor object logic of a heated capacitance
 * pressure sensor node. Takes one service request at a time from the
 * network layer and answers it; holds the corrected reading.
 * Assumes the network transport delivers decoded requests as a one-cycle
 * strobe, and that the front end supplies raw readings and conditions
 * already settled and filtered; those inputs come from other clock
 * domains and are synchronised here.
 */
//
// Overview of operation
// - Enable at 0 blocks and clears its alarm or warning bits.
// - Exception bits follow live conditions; nothing latches.
// - Alarm and warning enables come out of reset as 1.
// - Reading-valid detail bit is always 0 in alarm detail.
// - Service 0x0E reads an attribute; 0x10 writes one.
// - Service 5 resets the device into self-testing.
// - Service 6 moves the device into executing.
// - Service 7 moves the device into idle.
// - Service 0x4B moves the device into abort, also from inside.
// - Service 0x4C moves abort to idle, also from inside.
// - Service 0x4E runs the diagnostic routines.
// - Class revision attribute 1 is read-only and returns 0x0001.
// - Class subclass attribute 99 is not supported.
// - Required attributes behave as specified; optional sets may be read-only.
// - Sensor object lives at class 0x31 under supervisor control.
// - Reading is corrected with an offset and a gain.
// - Device detail: valid, over, under; maker detail: over temperature.
// - Data type accepts 0xC3 or 0xCA, only idle and unconnected.
// - Value equals gain times (reading plus offset A), plus offset B.
// - Status bits: high alarm, low alarm, high warning, low warning.
`timescale 1ns/1ps
`default_nettype none
module ssv_top
	import ssv_pkg::*;
#(
	parameter logic signed [15:0] OFS_A = 16'sh0000,
	parameter logic signed [15:0] GAIN  = 16'sh0100,
	parameter int                 DIAG_LEN = DIAG_CYCLES
) (
	input  wire logic        clk_sys_i,
	input  wire logic        arst_n_i,
	input  wire logic        req_valid_i,
	input  wire logic [7:0]  req_service_i,
	input  wire logic [7:0]  req_class_i,
	input  wire logic [7:0]  req_instance_i,
	input  wire logic [7:0]  req_attr_i,
	input  wire logic [15:0] req_data_i,
	input  wire logic        int_abort_i,
	input  wire logic        int_recover_i,
	input  wire logic        io_conn_i,
	input  wire logic [15:0] raw_reading_i,
	input  wire logic        reading_ok_i,
	input  wire logic        over_temp_i,
	input  wire logic [3:0]  cond_i,
	input  wire logic        diag_fail_i,
	output logic             rsp_valid_o,
	output logic [7:0]       rsp_error_o,
	output logic [15:0]      rsp_data_o,
	output logic [4:0]       state_o,
	output logic [15:0]      value_o,
	output logic [7:0]       status_o,
	output logic             busy_o
);
	// The diagnostic counter is 16 bits wide and must load a nonzero count.
	if (DIAG_LEN < 1 || DIAG_LEN > 65535) begin
		$error("DIAG_LEN out of range");
	end

	////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers.

	logic        rst_s1_q;
	logic        rst_n_q;
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// Front-end levels come from another domain.  The multi-bit reading
	// is assumed to be held stable long enough that a torn sample is
	// corrected on the next cycle.
	localparam int SW = 16 + 1 + 1 + 4 + 1 + 1;
	logic [SW-1:0] sy1_q;
	logic [SW-1:0] sy2_q;
	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sy1_q <= '0;
			sy2_q <= '0;
		end else begin
			sy1_q <= {raw_reading_i, reading_ok_i, over_temp_i, cond_i,
				io_conn_i, diag_fail_i};
			sy2_q <= sy1_q;
		end
	end
	wire logic [15:0] raw_w   = sy2_q[SW-1 -: 16];
	wire logic        ok_w    = sy2_q[7];
	wire logic        temp_w  = sy2_q[6];
	wire logic [3:0]  cond_w  = sy2_q[5:2];
	wire logic        conn_w  = sy2_q[1];
	wire logic        dfail_w = sy2_q[0];

	////////////////////////////////////////////////////////////////////
	// Attribute storage and correction.

	ssv_state_t  state_q;
	logic [7:0]  fmt_q;
	logic [15:0] units_q;
	logic        alm_en_q;
	logic        wrn_en_q;
	logic [15:0] ofs_b_q;
	logic [15:0] diag_cnt_q;
	ssv_corr_if  corr_c ();

	assign corr_c.raw   = raw_w;
	assign corr_c.ofs_a = OFS_A;
	assign corr_c.gain  = GAIN;
	assign corr_c.ofs_b = ofs_b_q;

	ssv_corr u_corr (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_q),
		.c         (corr_c)
	);

	wire logic       valid_w = ok_w & ~corr_c.ovr & ~corr_c.unr;
	wire logic [7:0] dev_raw_w = {5'h00, corr_c.unr, corr_c.ovr, valid_w};
	// valid bit zero in alarm detail
	wire logic [7:0] alm_det_w = alm_en_q ?
		(dev_raw_w & ~(8'h01 << DET_VALID)) : 8'h00;
	wire logic [7:0] wrn_det_w = wrn_en_q ? dev_raw_w : 8'h00;
	wire logic [7:0] mfg_alm_w = alm_en_q ? {7'h00, temp_w} : 8'h00;
	wire logic [7:0] mfg_wrn_w = wrn_en_q ? {7'h00, temp_w} : 8'h00;

	wire logic [7:0] status_w = {4'h0,
		wrn_en_q & cond_w[ST_LO_WRN], wrn_en_q & cond_w[ST_HI_WRN],
		alm_en_q & cond_w[ST_LO_ALM], alm_en_q & cond_w[ST_HI_ALM]};

	////////////////////////////////////////////////////////////////////
	// Request decode.

	wire logic is_sens_w  = req_class_i == CLS_SENSOR;
	wire logic is_super_w = req_class_i == CLS_SUPER;
	wire logic cls_lvl_w  = req_instance_i == 8'h00;
	wire logic is_get_w   = req_service_i == SVC_GET;
	wire logic is_set_w   = req_service_i == SVC_SET;
	wire logic diag_run_w = diag_cnt_q != 16'h0000;

	logic [7:0]  get_err_w;
	logic [15:0] get_dat_w;
	always_comb begin
		get_err_w = ERR_NONE;
		get_dat_w = 16'h0000;
		if (is_sens_w && cls_lvl_w) begin
			if (req_attr_i == ATT_REVISION)
				get_dat_w = CLS_REV_VAL;
			else
				get_err_w = ERR_NO_ATTR;
		end else if (is_sens_w) begin
			case (req_attr_i)
				ATT_FORMAT: get_dat_w = {8'h00, fmt_q};
				ATT_UNITS:  get_dat_w = units_q;
				ATT_VALID:  get_dat_w = {15'h0000, valid_w};
				ATT_VALUE:  get_dat_w = value_o;
				ATT_STATUS: get_dat_w = {8'h00, status_w};
				ATT_ALM_EN: get_dat_w = {15'h0000, alm_en_q};
				ATT_WRN_EN: get_dat_w = {15'h0000, wrn_en_q};
				ATT_SPAN:   get_dat_w = SPAN_VAL;
				ATT_OFS_B:  get_dat_w = ofs_b_q;
				default:    get_err_w = ERR_NO_ATTR;
			endcase
		end else if (is_super_w && !cls_lvl_w) begin
			case (req_attr_i)
				ATT_STATE:   get_dat_w = {11'h000, state_q};
				ATT_ALM_DET: get_dat_w = {8'h00, alm_det_w};
				ATT_WRN_DET: get_dat_w = {8'h00, wrn_det_w};
				ATT_MFG_ALM: get_dat_w = {8'h00, mfg_alm_w};
				ATT_MFG_WRN: get_dat_w = {8'h00, mfg_wrn_w};
				default:     get_err_w = ERR_NO_ATTR;
			endcase
		end else begin
			get_err_w = ERR_OBJECT;
		end
	end

	logic [7:0] set_err_w;
	always_comb begin
		set_err_w = ERR_NONE;
		if (!is_sens_w || cls_lvl_w) begin
			set_err_w = (is_sens_w || is_super_w) ? ERR_RO_ATTR : ERR_OBJECT;
		end else begin
			case (req_attr_i)
				ATT_FORMAT: begin
					if (state_q != ST_IDLE || conn_w)
						set_err_w = ERR_STATE;
					else if (req_data_i != {8'h00, FMT_INT} &&
						req_data_i != {8'h00, FMT_REAL})
						set_err_w = ERR_VALUE;
				end
				ATT_UNITS: begin
					if (state_q != ST_IDLE)
						set_err_w = ERR_STATE;
				end
				ATT_ALM_EN, ATT_WRN_EN: begin
					if (req_data_i > 16'h0001)
						set_err_w = ERR_VALUE;
				end
				ATT_OFS_B: set_err_w = ERR_NONE;
				ATT_VALID, ATT_VALUE, ATT_STATUS, ATT_SPAN:
					set_err_w = ERR_RO_ATTR;
				default: set_err_w = ERR_NO_ATTR;
			endcase
		end
	end

	logic       svc_ok_w;
	ssv_state_t svc_next_w;
	always_comb begin
		svc_ok_w   = 1'b1;
		svc_next_w = state_q;
		case (req_service_i)
			SVC_RESET: svc_next_w = ST_SELFTEST;
			SVC_START: begin
				svc_ok_w   = state_q == ST_IDLE;
				svc_next_w = ST_EXEC;
			end
			SVC_STOP: begin
				svc_ok_w   = state_q == ST_EXEC;
				svc_next_w = ST_IDLE;
			end
			SVC_ABORT: begin
				svc_ok_w   = state_q == ST_IDLE || state_q == ST_EXEC;
				svc_next_w = ST_ABORT;
			end
			SVC_RECOVER: begin
				svc_ok_w   = state_q == ST_ABORT;
				svc_next_w = ST_IDLE;
			end
			SVC_DIAG: svc_ok_w = state_q == ST_IDLE && !diag_run_w;
			default:  svc_ok_w = 1'b0;
		endcase
	end

	wire logic is_ctl_w = !is_get_w && !is_set_w;
	wire logic ctl_obj_w = is_super_w && !cls_lvl_w;
	wire logic [7:0] ctl_err_w = !ctl_obj_w ? ERR_SERVICE :
		!svc_ok_w ? ERR_STATE : ERR_NONE;
	wire logic [7:0] err_w = is_get_w ? get_err_w :
		is_set_w ? set_err_w : ctl_err_w;
	wire logic do_set_w = req_valid_i && is_set_w && set_err_w == ERR_NONE;
	wire logic do_ctl_w = req_valid_i && is_ctl_w && ctl_err_w == ERR_NONE;

	////////////////////////////////////////////////////////////////////
	// Supervisor state and diagnostics.

	// Self-test reuses the diagnostic counter; a failure lands in fault.
	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q    <= ST_SELFTEST;
			diag_cnt_q <= 16'(DIAG_LEN);
		end else if (do_ctl_w && req_service_i == SVC_RESET) begin
			state_q    <= ST_SELFTEST;
			diag_cnt_q <= 16'(DIAG_LEN);
		end else if (do_ctl_w && req_service_i == SVC_DIAG) begin
			diag_cnt_q <= 16'(DIAG_LEN);
		end else if (do_ctl_w) begin
			state_q <= svc_next_w;
		end else if (int_abort_i &&
			(state_q == ST_IDLE || state_q == ST_EXEC)) begin
			state_q <= ST_ABORT;
		end else if (int_recover_i && state_q == ST_ABORT) begin
			state_q <= ST_IDLE;
		end else if (diag_run_w) begin
			diag_cnt_q <= diag_cnt_q - 16'h0001;
			if (dfail_w)
				state_q <= ST_FAULT;
			else if (diag_cnt_q == 16'h0001 && state_q == ST_SELFTEST)
				state_q <= ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Settable attributes.

	// writing 0 clears gated bits at once
	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fmt_q    <= FMT_INT;
			units_q  <= UNITS_RST;
			alm_en_q <= ENABLE_RST;
			wrn_en_q <= ENABLE_RST;
			ofs_b_q  <= OFS_B_RST;
		end else if (do_set_w) begin
			case (req_attr_i)
				ATT_FORMAT: fmt_q    <= req_data_i[7:0];
				ATT_UNITS:  units_q  <= req_data_i;
				ATT_ALM_EN: alm_en_q <= req_data_i[0];
				ATT_WRN_EN: wrn_en_q <= req_data_i[0];
				ATT_OFS_B:  ofs_b_q  <= req_data_i;
				default:    ofs_b_q  <= ofs_b_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registered outputs.

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rsp_valid_o <= 1'b0;
			rsp_error_o <= ERR_NONE;
			rsp_data_o  <= 16'h0000;
			value_o     <= 16'h0000;
			status_o    <= 8'h00;
			state_o     <= ST_SELFTEST;
			busy_o      <= 1'b1;
		end else begin
			rsp_valid_o <= req_valid_i;
			if (req_valid_i) begin
				rsp_error_o <= err_w;
				rsp_data_o  <= (is_get_w && err_w == ERR_NONE) ?
					get_dat_w : 16'h0000;
			end
			// Outside executing the value holds its last reading.
			if (state_q == ST_EXEC)
				value_o <= corr_c.result;
			status_o <= status_w;
			state_o  <= state_q;
			busy_o   <= diag_run_w;
		end
	end
endmodule
`default_nettype wire

// ==== ssv_top_props.sv ====
/*
 * Checker for the supervisor top: answer timing, state moves, status
 * shape and the frozen reading outside execution.
 * Assumes it is bound to ssv_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module ssv_top_props
	import ssv_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        arst_n_i,
	input wire logic        req_valid_i,
	input wire logic [7:0]  req_service_i,
	input wire logic [7:0]  req_class_i,
	input wire logic [7:0]  req_instance_i,
	input wire logic        int_abort_i,
	input wire logic        int_recover_i,
	input wire logic [3:0]  cond_i,
	input wire logic        rsp_valid_o,
	input wire logic [7:0]  rsp_error_o,
	input wire logic [4:0]  state_o,
	input wire logic [15:0] value_o,
	input wire logic [7:0]  status_o,
	input wire logic        busy_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	// Internal requests are excluded so a network move is judged alone.
	wire logic ctl_req = req_valid_i && req_class_i == CLS_SUPER &&
		req_instance_i == 8'h01 && !int_abort_i && !int_recover_i;

	property p_move(logic [7:0] svc, logic [4:0] from, logic [4:0] to);
		ctl_req && req_service_i == svc && !busy_o &&
			(state_o & from) != 5'h00 |-> ##2 state_o == to;
	endproperty

	a_answer_next: assert property (req_valid_i |=> rsp_valid_o)
		else $error("answer strobe missing after a request");
	a_answer_caused: assert property (rsp_valid_o |-> $past(req_valid_i))
		else $error("answer strobe without a request");
	a_reset_selftest: assert property (ctl_req &&
		req_service_i == SVC_RESET |-> ##2 state_o == ST_SELFTEST)
		else $error("reset did not reach self-test");
	a_start_exec: assert property (p_move(SVC_START, ST_IDLE, ST_EXEC))
		else $error("start did not reach executing");
	a_stop_idle: assert property (p_move(SVC_STOP, ST_EXEC, ST_IDLE))
		else $error("stop did not reach idle");
	a_abort_entry: assert property (
		p_move(SVC_ABORT, ST_IDLE | ST_EXEC, ST_ABORT))
		else $error("abort did not reach abort");
	a_recover_idle: assert property (
		p_move(SVC_RECOVER, ST_ABORT, ST_IDLE))
		else $error("recover did not reach idle");
	a_diag_busy: assert property (ctl_req && req_service_i == SVC_DIAG &&
		state_o == ST_IDLE && !busy_o |-> ##[1:2] busy_o)
		else $error("diagnostics did not start");
	a_one_state: assert property ($onehot(state_o))
		else $error("state is not one-hot");
	a_refused_holds: assert property (ctl_req && !busy_o &&
		state_o != ST_SELFTEST ##1 rsp_error_o != ERR_NONE |=> $stable(state_o))
		else $error("refused request changed the state");
	a_status_rsvd: assert property (status_o[7:4] == 4'h0)
		else $error("reserved status bits set");
	a_no_latch: assert property ((cond_i == 4'h0) [*5] |->
		status_o[3:0] == 4'h0) else $error("status held a past condition");
	a_value_frozen: assert property ((state_o != ST_EXEC) [*4] |->
		$stable(value_o)) else $error("value moved outside executing");

	c_exec: cover property (state_o == ST_EXEC);
	c_abort: cover property (state_o == ST_ABORT);
	c_refused: cover property (rsp_valid_o && rsp_error_o != ERR_NONE);
	c_busy: cover property (busy_o && state_o == ST_IDLE);
endmodule

bind ssv_top ssv_top_props ssv_top_props_i (
	.clk_sys_i     (clk_sys_i),
	.arst_n_i      (arst_n_i),
	.req_valid_i   (req_valid_i),
	.req_service_i (req_service_i),
	.req_class_i   (req_class_i),
	.req_instance_i(req_instance_i),
	.int_abort_i   (int_abort_i),
	.int_recover_i (int_recover_i),
	.cond_i        (cond_i),
	.rsp_valid_o   (rsp_valid_o),
	.rsp_error_o   (rsp_error_o),
	.state_o       (state_o),
	.value_o       (value_o),
	.status_o      (status_o),
	.busy_o        (busy_o)
);
`default_nettype wire

// ==== ssv_master_model.sv ====
/*
 * Network master model: one request at a time, then its answer.
 * Assumes the answer strobe comes one cycle after the request edge.
 */
`timescale 1ns/1ps
`default_nettype none
module ssv_master_model (
	input  wire logic        clk_sys_i,
	input  wire logic        rsp_valid_i,
	input  wire logic [7:0]  rsp_error_i,
	input  wire logic [15:0] rsp_data_i,
	output logic             req_valid_o,
	output logic [31:0]      req_addr_o,
	output logic [15:0]      req_data_o
);
	initial begin
		req_valid_o = 1'b0;
		req_addr_o = 32'h0;
		req_data_o = 16'h0;
	end

	task automatic send(input logic [31:0] a, input logic [15:0] d,
		output logic [7:0] e, output logic [15:0] q, output bit ok);
		ok = 1'b0;
		@(posedge clk_sys_i);
		req_valid_o <= 1'b1;
		req_addr_o <= a;
		req_data_o <= d;
		@(posedge clk_sys_i);
		// Stale fields are inverted so a late sample cannot pass.
		req_valid_o <= 1'b0;
		req_addr_o <= ~a;
		req_data_o <= ~d;
		// The answer is read at a rising edge, before that edge's updates.
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge clk_sys_i);
			if (rsp_valid_i === 1'b1) begin
				ok = 1'b1;
				e = rsp_error_i;
				q = rsp_data_i;
			end
		end
	endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
/*
 * Self-checking testbench for the supervisor top with a master model.
 * Assumes a short self-test length and a gain of two.
 */
`timescale 1ns/1ps
`default_nettype none
module tb
	import ssv_pkg::*;
;
	localparam logic signed [15:0] T_GAIN = 16'sh0200;
	localparam logic signed [15:0] T_OFS_A = 16'sh0003;
	localparam logic [15:0] T_RAW = 16'h0064;
	localparam int VAL_EXP = (int'(T_GAIN) * (int'(T_RAW) + int'(T_OFS_A))) / 256 + 5;
	logic clk_sys_i = 1'b0;
	logic arst_n_i, int_abort_i, int_recover_i, io_conn_i;
	logic reading_ok_i, over_temp_i, diag_fail_i;
	logic [15:0] raw_reading_i, last_q;
	logic [3:0] cond_i;
	wire logic req_valid, rsp_valid, busy_o;
	wire logic [31:0] req_addr;
	wire logic [7:0] rsp_error, status_o;
	wire logic [15:0] req_data, rsp_data, value_o;
	wire logic [4:0] state_o;
	int n_mismatch = 0;
	int total_checks = 0;

	always #2.5 clk_sys_i = ~clk_sys_i;

	ssv_top #(.OFS_A(T_OFS_A), .GAIN(T_GAIN), .DIAG_LEN(8)) ssv_top_i (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid),
		.req_service_i(req_addr[31:24]), .req_class_i(req_addr[23:16]),
		.req_instance_i(req_addr[15:8]), .req_attr_i(req_addr[7:0]),
		.req_data_i(req_data), .int_abort_i(int_abort_i),
		.int_recover_i(int_recover_i), .io_conn_i(io_conn_i),
		.raw_reading_i(raw_reading_i), .reading_ok_i(reading_ok_i),
		.over_temp_i(over_temp_i), .cond_i(cond_i), .diag_fail_i(diag_fail_i),
		.rsp_valid_o(rsp_valid), .rsp_error_o(rsp_error), .rsp_data_o(rsp_data),
		.state_o(state_o), .value_o(value_o), .status_o(status_o),
		.busy_o(busy_o));
	ssv_master_model ssv_master_model_i (
		.clk_sys_i(clk_sys_i), .rsp_valid_i(rsp_valid), .rsp_error_i(rsp_error),
		.rsp_data_i(rsp_data), .req_valid_o(req_valid), .req_addr_o(req_addr),
		.req_data_o(req_data));

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
		total_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask
	// A code of FF accepts any refusal where the exact code is open.
	task automatic req(input logic [31:0] a, input logic [15:0] d, input logic [7:0] ee);
		logic [7:0] e;
		bit ok;
		ssv_master_model_i.send(a, d, e, last_q, ok);
		chk("answer strobe", 16'h0001, {15'h0, ok});
		if (!ok) print_verdict();
		if (ee == 8'hFF) chk("refusal", 16'h0001, {15'h0, e != ERR_NONE});
		else chk("answer code", {8'h00, ee}, {8'h00, e});
	endtask
	task automatic get(input logic [15:0] cna, input logic [7:0] a, input logic [15:0] x);
		req({SVC_GET, cna, a}, 16'h0000, ERR_NONE);
		chk("attribute data", x, last_q);
	endtask
	task automatic put(input logic [7:0] a, input logic [15:0] d, input logic [7:0] ee);
		req({SVC_SET, CLS_SENSOR, 8'h01, a}, d, ee);
	endtask
	function automatic logic [15:0] pick(input int k);
		case (k)
			0: return {11'h0, state_o};
			1: return {8'h00, status_o};
			2: return value_o;
			default: return {15'h0, busy_o};
		endcase
	endfunction
	task automatic wait_val(input int k, input logic [15:0] x);
		for (int i = 0; i < 40 && pick(k) !== x; i++) @(posedge clk_sys_i);
		chk("watched output", x, pick(k));
		if (pick(k) !== x) print_verdict();
	endtask
	task automatic ctl(input logic [7:0] s, input logic [7:0] ee, input logic [4:0] st);
		req({s, CLS_SUPER, 8'h01, ATT_STATE}, 16'h0000, ee);
		wait_val(0, {11'h0, st});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_attrs();
		wait_val(0, {11'h0, ST_IDLE}); // self-test ends
		get({CLS_SENSOR, 8'h01}, ATT_FORMAT, {8'h00, FMT_INT}); // default
		get({CLS_SENSOR, 8'h01}, ATT_UNITS, UNITS_RST); // units default
		get({CLS_SENSOR, 8'h01}, ATT_ALM_EN, 16'h0001); // enabled
		get({CLS_SENSOR, 8'h01}, ATT_WRN_EN, 16'h0001); // enabled
		get({CLS_SENSOR, 8'h01}, ATT_OFS_B, OFS_B_RST); // offset default
		get({CLS_SENSOR, 8'h01}, ATT_SPAN, SPAN_VAL); // full scale
		get({CLS_SENSOR, 8'h00}, ATT_REVISION, CLS_REV_VAL); // revision
		req({SVC_GET, CLS_SENSOR, 8'h00, ATT_SUBCLASS}, 16'h0, ERR_NO_ATTR);
		put(ATT_VALUE, 16'h0001, ERR_RO_ATTR); // read-only
		req({SVC_GET, 8'h32, 8'h01, ATT_VALUE}, 16'h0, ERR_OBJECT);
	endtask
	task automatic t_format();
		put(ATT_FORMAT, {8'h00, FMT_REAL}, ERR_NONE); // float
		get({CLS_SENSOR, 8'h01}, ATT_FORMAT, {8'h00, FMT_REAL}); // readback
		put(ATT_FORMAT, 16'h0055, ERR_VALUE); // bad code
		io_conn_i <= 1'b1;
		tick(5);
		put(ATT_FORMAT, {8'h00, FMT_INT}, 8'hFF); // connected
		io_conn_i <= 1'b0;
		tick(5);
		put(ATT_FORMAT, {8'h00, FMT_INT}, ERR_NONE); // integer
	endtask
	task automatic t_alarm();
		cond_i <= 4'hF;
		wait_val(1, 16'h000F); // live conditions
		put(ATT_ALM_EN, 16'h0000, ERR_NONE); // disable
		wait_val(1, 16'h000C); // alarm cleared
		put(ATT_WRN_EN, 16'h0000, ERR_NONE); // disable
		wait_val(1, 16'h0000); // warning cleared
		put(ATT_ALM_EN, 16'h0002, ERR_VALUE); // boolean only
		put(ATT_ALM_EN, 16'h0001, ERR_NONE); // enable
		put(ATT_WRN_EN, 16'h0001, ERR_NONE); // enable
		get({CLS_SENSOR, 8'h01}, ATT_STATUS, 16'h000F); // status byte
		cond_i <= 4'h5;
		wait_val(1, 16'h0005); // follows
		cond_i <= 4'h0;
		wait_val(1, 16'h0000); // not latched
	endtask
	task automatic t_detail();
		get({CLS_SENSOR, 8'h01}, ATT_VALID, 16'h0001); // valid
		get({CLS_SUPER, 8'h01}, ATT_ALM_DET, 16'h0000); // alarm detail
		get({CLS_SUPER, 8'h01}, ATT_WRN_DET, 16'h0001); // warning detail
		reading_ok_i <= 1'b0;
		over_temp_i <= 1'b1;
		tick(6);
		get({CLS_SUPER, 8'h01}, ATT_WRN_DET, 16'h0000); // invalid
		get({CLS_SUPER, 8'h01}, ATT_MFG_WRN, 16'h0001); // over temp
		get({CLS_SUPER, 8'h01}, ATT_MFG_ALM, 16'h0001); // over temp
		reading_ok_i <= 1'b1;
		over_temp_i <= 1'b0;
		tick(6);
	endtask
	task automatic t_ctrl();
		put(ATT_OFS_B, 16'h0005, ERR_NONE); // second offset
		ctl(SVC_START, ERR_NONE, ST_EXEC); // start
		wait_val(2, 16'(VAL_EXP)); // corrected value
		get({CLS_SENSOR, 8'h01}, ATT_VALUE, 16'(VAL_EXP)); // reading
		put(ATT_FORMAT, {8'h00, FMT_REAL}, 8'hFF); // not idle
		ctl(SVC_START, ERR_STATE, ST_EXEC); // refused
		ctl(SVC_STOP, ERR_NONE, ST_IDLE); // stop
		ctl(SVC_ABORT, ERR_NONE, ST_ABORT); // abort
		ctl(SVC_START, ERR_STATE, ST_ABORT); // refused
		ctl(SVC_RECOVER, ERR_NONE, ST_IDLE); // recover
		int_abort_i <= 1'b1;
		tick(1);
		int_abort_i <= 1'b0;
		wait_val(0, {11'h0, ST_ABORT}); // internal abort
		int_recover_i <= 1'b1;
		tick(1);
		int_recover_i <= 1'b0;
		wait_val(0, {11'h0, ST_IDLE}); // internal recover
		ctl(SVC_DIAG, ERR_NONE, ST_IDLE); // diagnostics
		wait_val(3, 16'h0001); // running
		wait_val(3, 16'h0000); // finished
		ctl(SVC_RESET, ERR_NONE, ST_SELFTEST); // reset
		wait_val(0, {11'h0, ST_IDLE}); // self-test ends
		diag_fail_i <= 1'b1;
		ctl(SVC_RESET, ERR_NONE, ST_SELFTEST); // reset
		wait_val(0, {11'h0, ST_FAULT}); // failed self-test
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		arst_n_i = 1'b0;
		{int_abort_i, int_recover_i, io_conn_i} = 3'h0;
		{over_temp_i, diag_fail_i} = 2'h0;
		reading_ok_i = 1'b1;
		raw_reading_i = T_RAW;
		cond_i = 4'h0;
		tick(5);
		chk("state in reset", 16'h0001, {11'h0, state_o}); // self-test
		arst_n_i <= 1'b1;
		t_attrs();
		t_format();
		t_alarm();
		t_detail();
		t_ctrl();
		print_verdict();
	end
endmodule
`default_nettype wire
